// *** verilog/qbp_port.sv ***
// Purpose: Pin logic of an eight-bit quasi-bidirectional port with
//          serial, interrupt and timer alternate functions
// Assumes: port_latch, ser_alt and irq_cfg come from clk_sys logic;
//          pin_in and rst_pin are asynchronous pads
// Notes:   Pad cell resolves o/oe/strong_pu/weak_pu into the pin level

`include "qbp_map.svh"

module qbp_port #(
	parameter int STRONG_CYC = `QBP_STRONG_CYC,
	parameter int HOLD_CYC   = `QBP_RST_HOLD_CYC
)(
	input  wire logic                 clk_sys,
	input  wire logic                 rstn,
	input  wire qbp_pkg::qbp_byte_t   port_latch,
	input  wire qbp_pkg::qbp_byte_t   pin_in,
	input  wire logic                 rst_pin,
	input  wire qbp_pkg::qbp_ser_t    ser_alt,
	input  wire qbp_pkg::qbp_irq_cfg_t irq_cfg,
	output qbp_pkg::qbp_pad_t         pad,
	output qbp_pkg::qbp_byte_t        pin_rd,
	output logic                      uart_rxd,
	output qbp_pkg::qbp_irq_t         irq,
	output qbp_pkg::qbp_tmr_t         tmr,
	output logic                      core_rst_req
);

	localparam qbp_pkg::qbp_scnt_t STRONG_V = STRONG_CYC[`QBP_CNT_W-1:0];
	localparam qbp_pkg::qbp_scnt_t SCNT_ONE = `QBP_CNT_W'(1);

	if (STRONG_CYC < 1 || STRONG_CYC >= (1 << `QBP_CNT_W))
	begin : g_chk
		$error("qbp_port: STRONG_CYC out of range");
	end

	// Port comes out of reset as all inputs on weak pull-ups
	localparam qbp_pkg::qbp_port_st_t ST_RST = '{
		s1:       `QBP_PIN_RST,
		s2:       `QBP_PIN_RST,
		s3:       `QBP_PIN_RST,
		filt:     `QBP_PIN_RST,
		pad:      '{o:         `QBP_EFF_RST,
		            oe:        `QBP_NONE,
		            strong_pu: `QBP_NONE,
		            weak_pu:   `QBP_EFF_RST},
		scnt:     '0,
		irq_flag: 2'h0,
		irq:      '{req: 2'h0, hi_prio: 2'h0}
	};

	qbp_pkg::qbp_port_st_t st_r;
	qbp_pkg::qbp_port_st_t st_nxt;

	wire qbp_pkg::qbp_byte_t              alt_o;
	wire qbp_pkg::qbp_byte_t              eff_n;
	wire qbp_pkg::qbp_byte_t              filt_n;
	wire qbp_pkg::qbp_byte_t              strong_n;
	wire qbp_pkg::qbp_scnt_t [`QBP_PORT_W-1:0] scnt_n;

	// ----------------------------------------------------------------
	// Alternate-function outputs
	// ----------------------------------------------------------------
	// Bits without an output function idle at one so the latch rules
	assign alt_o = {
		{(`QBP_PORT_W-2){1'h1}},
		ser_alt.sync_mode ? ser_alt.shift_clk : ser_alt.txd,
		ser_alt.sync_mode ? ser_alt.sdata_o : 1'h1
	};

	// ----------------------------------------------------------------
	// Per-bit input filter and pull-up sequencing
	// ----------------------------------------------------------------
	for (genvar i = 0; i < `QBP_PORT_W; i++)
	begin : g_bit
		logic rise;

		// Level moves only once the second and third flops agree
		assign filt_n[i] = (st_r.s2[i] == st_r.s3[i]) ?
		                   st_r.s3[i] : st_r.filt[i];
		assign eff_n[i]  = port_latch[i] & alt_o[i];
		assign rise      = eff_n[i] & ~st_r.pad.o[i];
		// Strong boost is dropped at once if the bit goes low again
		assign scnt_n[i] = rise ? STRONG_V :
		                   (eff_n[i] && st_r.scnt[i] != '0) ?
		                   st_r.scnt[i] - SCNT_ONE : '0;
		assign strong_n[i] = (scnt_n[i] != '0);

		strong_pulse_a : assert property (@(posedge clk_sys)
			disable iff (!rstn)
			$rose(pad.o[i]) |->
			pad.strong_pu[i] ##1 (pad.strong_pu[i] || !pad.o[i]))
			else $error("strong pull-up missing after rising output");

		sequence s_high_three;
			pad.o[i] [*3];
		endsequence

		strong_end_a : assert property (@(posedge clk_sys)
			disable iff (!rstn)
			s_high_three |-> !pad.strong_pu[i])
			else $error("strong pull-up held past two cycles");

		weak_hold_a : assert property (@(posedge clk_sys)
			disable iff (!rstn)
			(pad.o[i] && !pad.strong_pu[i]) |->
			(pad.weak_pu[i] && !pad.oe[i]))
			else $error("high bit not left on weak pull-up");

		low_drive_a : assert property (@(posedge clk_sys)
			disable iff (!rstn)
			!pad.o[i] |-> (pad.oe[i] && !pad.weak_pu[i]))
			else $error("low bit not driven");
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Edge flags: a falling edge in the ack cycle still sets the flag
	always_comb
	begin
		logic [1:0] lvl;
		logic [1:0] fell;
		logic [1:0] flag;
		lvl  = {filt_n[`QBP_BIT_IRQ_ONE], filt_n[`QBP_BIT_IRQ_ZERO]};
		fell = {st_r.filt[`QBP_BIT_IRQ_ONE], st_r.filt[`QBP_BIT_IRQ_ZERO]}
		       & ~lvl;
		flag = fell | (st_r.irq_flag & ~irq_cfg.ack);
		st_nxt               = st_r;
		st_nxt.s1            = pin_in;
		st_nxt.s2            = st_r.s1;
		st_nxt.s3            = st_r.s2;
		st_nxt.filt          = filt_n;
		st_nxt.pad.o         = eff_n;
		st_nxt.pad.strong_pu = strong_n;
		st_nxt.pad.oe        = ~eff_n | strong_n;
		st_nxt.pad.weak_pu   = eff_n & ~strong_n;
		st_nxt.scnt          = scnt_n;
		st_nxt.irq_flag      = flag;
		// Level mode requests while the pin is low, edge mode on a flag
		st_nxt.irq.req       = (irq_cfg.edge_mode & flag) |
		                       (~irq_cfg.edge_mode & ~lvl);
		st_nxt.irq.hi_prio   = irq_cfg.hi_prio;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			st_r <= ST_RST;
		else
			st_r <= st_nxt;
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from state flops
	// ----------------------------------------------------------------
	assign pad      = st_r.pad;
	assign pin_rd   = st_r.filt;
	assign uart_rxd = st_r.filt[`QBP_BIT_SER_DATA];
	assign irq      = st_r.irq;
	// Gating sees the filtered pin, never a raw pad sample
	assign tmr      = '{
		gate:     {st_r.filt[`QBP_BIT_IRQ_ONE],
		           st_r.filt[`QBP_BIT_IRQ_ZERO]},
		count_in: {st_r.filt[`QBP_BIT_CNT_ONE],
		           st_r.filt[`QBP_BIT_CNT_ZERO]}
	};

	// ----------------------------------------------------------------
	// Reset qualifier
	// ----------------------------------------------------------------
	qbp_rst_qual #(
		.HOLD_CYC     (HOLD_CYC)
	) u_rst_qual (
		.clk_sys      (clk_sys),
		.rstn         (rstn),
		.rst_pin      (rst_pin),
		.core_rst_req (core_rst_req)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	sequence s_rx_high;
		pin_in[`QBP_BIT_SER_DATA] [*5];
	endsequence

	sequence s_irq_pending;
		$past(irq_cfg.edge_mode[0]) && irq.req[0] && !irq_cfg.ack[0];
	endsequence

	latch_and_a : assert property (
		$past(rstn) |->
		pad.o[`QBP_BIT_IRQ_ZERO] == $past(port_latch[`QBP_BIT_IRQ_ZERO]))
		else $error("pin output does not follow latch");

	ser_tx_a : assert property (
		$past(rstn) |-> pad.o[`QBP_BIT_SER_TX] ==
		$past(port_latch[`QBP_BIT_SER_TX] & (ser_alt.sync_mode ?
		      ser_alt.shift_clk : ser_alt.txd)))
		else $error("bit one not driven by transmit or shift clock");

	ser_sync_a : assert property (
		($past(rstn) && $past(ser_alt.sync_mode)) |->
		pad.o[`QBP_BIT_SER_DATA] ==
		$past(port_latch[`QBP_BIT_SER_DATA] & ser_alt.sdata_o))
		else $error("bit zero not driven by synchronous data");

	ser_rx_a : assert property (
		s_rx_high |-> uart_rxd && pin_rd[`QBP_BIT_SER_DATA])
		else $error("receive input does not follow held pin");

	sync_depth_a : assert property (
		$rose(pin_rd[`QBP_BIT_IRQ_ZERO]) |->
		$past(pin_in[`QBP_BIT_IRQ_ZERO], 3) &&
		$past(pin_in[`QBP_BIT_IRQ_ZERO], 4))
		else $error("pin read changed without two agreeing samples");

	irq_edge_a : assert property (
		($past(irq_cfg.edge_mode[0]) &&
		 $fell(pin_rd[`QBP_BIT_IRQ_ZERO])) |-> irq.req[0])
		else $error("falling edge did not request interrupt zero");

	irq_hold_a : assert property (
		s_irq_pending ##0 irq_cfg.edge_mode[0] |=> irq.req[0])
		else $error("edge request lost before acknowledge");

	irq_level_a : assert property (
		($past(rstn) && !$past(irq_cfg.edge_mode[1])) |->
		irq.req[1] == !pin_rd[`QBP_BIT_IRQ_ONE])
		else $error("level request one does not follow pin");

	gate_one_a : assert property (
		pin_in[`QBP_BIT_IRQ_ONE] [*5] |-> tmr.gate[1])
		else $error("timer one gate does not follow held high pin");

	gate_zero_a : assert property (
		!pin_in[`QBP_BIT_IRQ_ZERO] [*5] |-> !tmr.gate[0])
		else $error("timer zero gate does not follow held low pin");

endmodule

// *** verilog/qbp_map.svh ***
// Purpose: Constants for the quasi-bidirectional port and reset qualifier
// Assumes: One core clock, clk_sys, at 40 MHz
// Notes:   Included by the package and by both design modules

`ifndef QBP_MAP_SVH
`define QBP_MAP_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define QBP_PORT_W        8
`define QBP_CNT_W         2
`define QBP_RUN_W         6

// ----------------------------------------------------------------
// Bit positions of the alternate functions
// ----------------------------------------------------------------
`define QBP_BIT_SER_DATA  0
`define QBP_BIT_SER_TX    1
`define QBP_BIT_IRQ_ZERO  2
`define QBP_BIT_IRQ_ONE   3
`define QBP_BIT_CNT_ZERO  4
`define QBP_BIT_CNT_ONE   5

// ----------------------------------------------------------------
// Timing counts and reset values
// ----------------------------------------------------------------
`define QBP_STRONG_CYC    2
`define QBP_RST_HOLD_CYC  24
`define QBP_EFF_RST       8'hFF
`define QBP_PIN_RST       8'hFF
`define QBP_NONE          8'h00

`endif

// *** verilog/qbp_pkg.sv ***
// Purpose: Types shared by the port block and its reset qualifier
// Assumes: qbp_map.svh supplies widths
// Notes:   Carrier structs group pad, serial, interrupt and timer signals

`include "qbp_map.svh"

package qbp_pkg;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef logic [`QBP_PORT_W-1:0] qbp_byte_t;
	typedef logic [`QBP_CNT_W-1:0]  qbp_scnt_t;

	// Pad drive: o is the level, oe high while actively driven
	typedef struct packed {
		qbp_byte_t o;
		qbp_byte_t oe;
		qbp_byte_t strong_pu;
		qbp_byte_t weak_pu;
	} qbp_pad_t;

	typedef struct packed {
		logic sync_mode;
		logic txd;
		logic shift_clk;
		logic sdata_o;
	} qbp_ser_t;

	// Index 0 is external_irq_zero, index 1 external_irq_one
	typedef struct packed {
		logic [1:0] edge_mode;
		logic [1:0] hi_prio;
		logic [1:0] ack;
	} qbp_irq_cfg_t;

	typedef struct packed {
		logic [1:0] req;
		logic [1:0] hi_prio;
	} qbp_irq_t;

	// Index 0 is timer_zero, index 1 timer_one
	typedef struct packed {
		logic [1:0] gate;
		logic [1:0] count_in;
	} qbp_tmr_t;

	// ----------------------------------------------------------------
	// Module state
	// ----------------------------------------------------------------
	typedef struct packed {
		qbp_byte_t                  s1;
		qbp_byte_t                  s2;
		qbp_byte_t                  s3;
		qbp_byte_t                  filt;
		qbp_pad_t                   pad;
		qbp_scnt_t [`QBP_PORT_W-1:0] scnt;
		logic [1:0]                 irq_flag;
		qbp_irq_t                   irq;
	} qbp_port_st_t;

	typedef struct packed {
		logic                  s1;
		logic                  s2;
		logic                  s3;
		logic                  level;
		logic [`QBP_RUN_W-1:0] cnt;
		logic                  req;
	} qbp_rst_st_t;

endpackage

// *** verilog/qbp_rst_qual.sv ***
// Purpose: Qualifies the external reset pin into an internal reset request
// Assumes: rst_pin is asynchronous to clk_sys
// Notes:   Request is a level, held while the pin stays high

`include "qbp_map.svh"

module qbp_rst_qual #(
	parameter int HOLD_CYC = `QBP_RST_HOLD_CYC
)(
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic rst_pin,
	output logic      core_rst_req
);

	localparam logic [`QBP_RUN_W-1:0] HOLD_V  = HOLD_CYC[`QBP_RUN_W-1:0];
	localparam logic [`QBP_RUN_W-1:0] RUN_ONE = `QBP_RUN_W'(1);

	if (HOLD_CYC < 1 || HOLD_CYC >= (1 << `QBP_RUN_W))
	begin : g_chk
		$error("qbp_rst_qual: HOLD_CYC out of range");
	end

	qbp_pkg::qbp_rst_st_t st_r;
	qbp_pkg::qbp_rst_st_t st_nxt;

	// ----------------------------------------------------------------
	// Pin filter and high-time counter
	// ----------------------------------------------------------------
	// A lone glitch is ignored: the level moves only when s2 and s3 agree
	always_comb
	begin
		st_nxt       = st_r;
		st_nxt.s1    = rst_pin;
		st_nxt.s2    = st_r.s1;
		st_nxt.s3    = st_r.s2;
		st_nxt.level = (st_r.s2 == st_r.s3) ? st_r.s3 : st_r.level;
		if (!st_nxt.level)
			st_nxt.cnt = '0;
		else if (st_r.cnt != HOLD_V)
			st_nxt.cnt = st_r.cnt + RUN_ONE;
		st_nxt.req   = st_nxt.level && (st_nxt.cnt == HOLD_V);
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign core_rst_req = st_r.req;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// Helper: consecutive cycles with the filtered level high
	logic [`QBP_RUN_W-1:0] run_r;
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			run_r <= '0;
		else if (!st_r.level)
			run_r <= '0;
		else if (run_r != '1)
			run_r <= run_r + RUN_ONE;
	end

	rst_after_hold_a : assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(core_rst_req) |-> (run_r + RUN_ONE == HOLD_V))
		else $error("internal reset raised after wrong high time");

	rst_release_a : assert property (@(posedge clk_sys) disable iff (!rstn)
		$fell(st_r.level) |-> !core_rst_req)
		else $error("internal reset held after pin went low");

endmodule

// *** tb/qbp_board.sv ***
// Purpose: Board-side model of the eight port pins
// Assumes: Board can only pull a pin low; it never drives it high
// Notes:   A pin with no pull-up and no drive shows a toggling level

module qbp_board (
	clk_sys,
	pad,
	ext_low,
	pin_in
);
	timeunit 1ns;
	timeprecision 1ps;

	input  wire logic               clk_sys;
	input  wire qbp_pkg::qbp_pad_t  pad;
	input  wire qbp_pkg::qbp_byte_t ext_low;
	output qbp_pkg::qbp_byte_t      pin_in;

	qbp_pkg::qbp_byte_t float_r = 8'h55;

	// Floating pins change every cycle so a stale level never looks valid
	always @(posedge clk_sys)
		float_r <= ~float_r;

	// A low from either side wins; a pull-up alone only holds the pin high
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			if ((pad.oe[i] && !pad.o[i]) || ext_low[i])
				pin_in[i] = 1'b0;
			else if (pad.weak_pu[i] || pad.strong_pu[i])
				pin_in[i] = 1'b1;
			else
				pin_in[i] = float_r[i];
		end
	end
endmodule

// *** tb/test_qbp_port.sv ***
// Purpose: Self-checking bench for the quasi-bidirectional port block
// Assumes: Inputs change 2 ns after each rising edge of clk_sys
// Notes:   Latencies follow the three-flop pin filter of the block

module test_qbp_port;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int STRONG = 2;
	localparam int HOLD   = 24;
	localparam int LAT    = 4;

	logic                  clk_sys = 1'b0;
	logic                  rstn;
	qbp_pkg::qbp_byte_t    port_latch;
	qbp_pkg::qbp_byte_t    ext_low;
	qbp_pkg::qbp_byte_t    pin_in;
	logic                  rst_pin;
	qbp_pkg::qbp_ser_t     ser_alt;
	qbp_pkg::qbp_irq_cfg_t irq_cfg;
	qbp_pkg::qbp_pad_t     pad;
	qbp_pkg::qbp_byte_t    pin_rd;
	logic                  uart_rxd;
	qbp_pkg::qbp_irq_t     irq;
	qbp_pkg::qbp_tmr_t     tmr;
	logic                  core_rst_req;
	int                    errors = 0;
	int                    checks_done = 0;

	// 40 MHz core clock
	always #12.5 clk_sys = ~clk_sys;

	qbp_port #(.STRONG_CYC(STRONG), .HOLD_CYC(HOLD)) DUT (
		.clk_sys      (clk_sys),
		.rstn         (rstn),
		.port_latch   (port_latch),
		.pin_in       (pin_in),
		.rst_pin      (rst_pin),
		.ser_alt      (ser_alt),
		.irq_cfg      (irq_cfg),
		.pad          (pad),
		.pin_rd       (pin_rd),
		.uart_rxd     (uart_rxd),
		.irq          (irq),
		.tmr          (tmr),
		.core_rst_req (core_rst_req)
	);

	qbp_board board (
		.clk_sys (clk_sys),
		.pad     (pad),
		.ext_low (ext_low),
		.pin_in  (pin_in)
	);

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] seen);
		checks_done++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict;
		if (errors == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset_vals;
		check("pad", {8'hFF, 8'h00, 8'h00, 8'hFF}, pad);
		check("pin_rd", 8'hFF, pin_rd);
		check("rx", 1'b1, uart_rxd);
		check("irq", 4'h0, irq.req);
		check("tmr", 4'hF, tmr);
		check("rst_req", 1'b0, core_rst_req);
	endtask

	// Rising output gets exactly STRONG cycles of strong drive
	task automatic t_boost;
		port_latch[7] = 1'b0;
		tick(1);
		check("low oe", 2'b10, {pad.oe[7], pad.o[7]});
		tick(STRONG + 1);
		port_latch[7] = 1'b1;
		for (int k = 1; k <= STRONG + 1; k++)
		begin
			tick(1);
			check("strong", k <= STRONG, pad.strong_pu[7]);
			check("weak", k > STRONG, pad.weak_pu[7]);
			check("oe", k <= STRONG, pad.oe[7]);
			check("o", 1'b1, pad.o[7]);
		end
	endtask

	// Serial alternate outputs in both modes, gated by the latch
	task automatic t_alt;
		logic [3:0] sa_t [4];
		logic [1:0] lt_t [4];
		logic [1:0] ex_t [4];
		sa_t = '{4'b0011, 4'b0101, 4'b1100, 4'b1111};
		lt_t = '{2'b11, 2'b11, 2'b11, 2'b00};
		ex_t = '{2'b01, 2'b11, 2'b00, 2'b00};
		for (int k = 0; k < 4; k++)
		begin
			ser_alt = sa_t[k];
			port_latch[1:0] = lt_t[k];
			tick(1);
			check("alt o", ex_t[k], pad.o[1:0]);
		end
		ser_alt = 4'b0111;
		port_latch = 8'hFF;
		tick(STRONG + 2);
	endtask

	// Glitch is ignored; a held low reads back after the filter
	task automatic t_pin;
		ext_low = 8'h41;
		tick(1);
		ext_low = 8'h00;
		for (int k = 0; k < 6; k++)
		begin
			tick(1);
			check("glitch", 8'hFF, pin_rd);
		end
		ext_low = 8'h41;
		for (int k = 1; k <= LAT; k++)
		begin
			tick(1);
			check("pin_rd", (k < LAT) ? 8'hFF : 8'hBE, pin_rd);
			check("rx", k < LAT, uart_rxd);
		end
		ext_low = 8'h00;
		tick(LAT);
	endtask

	// Mode m: bit set means edge, cleared means level
	task automatic t_irq(input logic [1:0] m);
		irq_cfg.edge_mode = m;
		irq_cfg.hi_prio = m;
		tick(1);
		check("prio", m, irq.hi_prio);
		ext_low = 8'h0C;
		for (int k = 1; k <= LAT; k++)
		begin
			tick(1);
			check("req", (k < LAT) ? 2'b00 : 2'b11, irq.req);
		end
		tick(2);
		check("req held", 2'b11, irq.req);
		ext_low = 8'h00;
		tick(LAT);
		check("req rel", m, irq.req);
		// A fall in level mode sets the edge flag too, so clear both
		irq_cfg.ack = 2'b11;
		tick(1);
		irq_cfg.ack = 2'b00;
		check("req ack", 2'b00, irq.req);
	endtask

	// Timer gates and count inputs follow the filtered pins
	task automatic t_tmr;
		irq_cfg.ack = 2'b11;
		ext_low = 8'h14;
		tick(LAT);
		check("tmr a", 4'b1010, tmr);
		ext_low = 8'h28;
		tick(LAT);
		check("tmr b", 4'b0101, tmr);
		ext_low = 8'h00;
		tick(LAT);
		irq_cfg.ack = 2'b00;
		tick(1);
	endtask

	// One cycle short of the hold count, then the full count
	task automatic t_rst;
		rst_pin = 1'b1;
		tick(HOLD - 1);
		rst_pin = 1'b0;
		for (int k = 0; k < 8; k++)
		begin
			tick(1);
			check("short", 1'b0, core_rst_req);
		end
		rst_pin = 1'b1;
		for (int k = 1; k <= HOLD + 3; k++)
		begin
			tick(1);
			check("long", k >= HOLD + 3, core_rst_req);
		end
		rst_pin = 1'b0;
		for (int k = 1; k <= LAT; k++)
		begin
			tick(1);
			check("drop", k < LAT, core_rst_req);
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial
	begin
		rstn = 1'b0;
		port_latch = 8'hFF;
		ext_low = 8'h00;
		rst_pin = 1'b0;
		ser_alt = 4'b0111;
		irq_cfg = '0;
		tick(16);
		t_reset_vals();
		rstn = 1'b1;
		tick(1);
		t_reset_vals();
		t_boost();
		t_alt();
		t_pin();
		t_irq(2'b01);
		t_irq(2'b10);
		t_tmr();
		t_rst();
		print_verdict();
	end

	// Whole run needs well under 400 cycles
	initial
	begin
		repeat (3000) @(posedge clk_sys);
		errors++;
		print_verdict();
	end
endmodule
